// ### src/clock_source_switch.sv
// Device clock source selection with glitch-free switching
//
// How it works
// - Two-bit select picks primary, secondary or internal
// - Select change moves clock after short pause
// - Any reset clears the applied source selection
// - Frequency field picks slow RC, 8 MHz, or postscale
// - Frequency change takes effect on output at once
// - Lowest code: fast/256 if set, else slow RC
// - Watchdog always runs on slow RC
// - Primary running flag after start-up timer expires
// - Internal stable flag when block stable and driving, except on slow RC
// - Secondary running flag when secondary drives clock
// - At most one status flag set at once
// - Idle-on-sleep bit picks sleep or idle mode
// - Secondary select needs secondary oscillator enabled
// - Pause: two old cycles, three to four new
`timescale 1ns/1ps
module clock_source_switch (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       primaryOscIn,
  input  wire logic       secondaryOscIn,
  input  wire logic       fastInternalOscIn,
  input  wire logic       slowInternalRcIn,
  input  wire logic [1:0] clockSourceSelect,
  input  wire logic [2:0] internalFreqSelect,
  input  wire logic       lowFreqSourceChoice,
  input  wire logic       secondaryOscEnable,
  input  wire logic       primaryStartupDone,
  input  wire logic       internalOscReady,
  input  wire logic       idleOnSleepEnable,
  input  wire logic       sleepExecute,
  input  wire logic       wakeEvent,
  output logic            deviceClk,
  output logic            watchdogClk,
  output logic            primaryClockRunning,
  output logic            internalClockStable,
  output logic            secondaryClockRunning,
  output logic            sleepMode,
  output logic            idleMode,
  output logic            switchBusy
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    clk_switch_pkg::switch_state_t   swState;
    logic [1:0]                      curSel;
    logic [1:0]                      tgtSel;
    logic [1:0]                      edgeCnt;
    clk_switch_pkg::clk_lines_t      prevLines;
    logic                            prevFast;
    logic [clk_switch_pkg::POST_WIDTH-1:0] postDiv;
    logic                            devClk;
    logic                            wdtClk;
    clk_switch_pkg::status_t         status;
    logic                            sleepOn;
    logic                            idleOn;
  } state_t;

  localparam state_t STATE_RESET = '{
    swState:   clk_switch_pkg::SW_RUN,
    curSel:    clk_switch_pkg::SEL_RESET,
    tgtSel:    clk_switch_pkg::SEL_RESET,
    edgeCnt:   2'h0,
    prevLines: 3'h0,
    prevFast:  1'b0,
    postDiv:   clk_switch_pkg::POST_RESET,
    devClk:    1'b0,
    wdtClk:    1'b0,
    status:    3'h0,
    sleepOn:   1'b0,
    idleOn:    1'b0
  };

  state_t state_r;
  state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Folds both internal codes onto one value
  function automatic logic [1:0] normSel(input logic [1:0] sel);
    normSel = sel[1] ? clk_switch_pkg::SEL_INTERNAL : sel;
  endfunction : normSel

  // Level of the candidate line named by a normalised select
  function automatic logic lineOf(input clk_switch_pkg::clk_lines_t l,
                                  input logic [1:0] sel);
    case (sel)
      clk_switch_pkg::SEL_PRIMARY:   lineOf = l.primary;
      clk_switch_pkg::SEL_SECONDARY: lineOf = l.secondary;
      default:                       lineOf = l.internalBlock;
    endcase
  endfunction : lineOf

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  clk_switch_pkg::osc_lines_t oscRaw;
  clk_switch_pkg::osc_lines_t osc;

  assign oscRaw.primary      = primaryOscIn;
  assign oscRaw.secondary    = secondaryOscIn;
  assign oscRaw.fastInternal = fastInternalOscIn;
  assign oscRaw.slowRc       = slowInternalRcIn;

  // Every source passes two flops before any edge logic sees it
  osc_sync #(
    .WIDTH   (clk_switch_pkg::NUM_OSC)
  ) u_osc_sync (
    .core_clk(core_clk),
    .rstn    (rstn),
    .asyncIn (oscRaw),
    .syncOut (osc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Internal block output and edges

  logic                       postLevel;
  logic                       blockLevel;
  logic                       lowestUsesRc;
  logic [2:0]                 postBit;
  clk_switch_pkg::clk_lines_t lines;
  clk_switch_pkg::clk_lines_t rises;
  clk_switch_pkg::clk_lines_t falls;
  logic                       oldLevel;
  logic                       oldFall;
  logic                       newRise;
  logic                       newFall;
  logic [1:0]                 reqSel;
  logic                       reqValid;

  // Postscaler tap picked straight from the live field, no retiming
  always_comb begin
    postBit      = clk_switch_pkg::FREQ_TOP_POST - internalFreqSelect;
    postLevel    = state_r.postDiv[postBit];
    lowestUsesRc = !lowFreqSourceChoice;
    if (internalFreqSelect == clk_switch_pkg::FREQ_FULL) begin
      blockLevel = osc.fastInternal;
    end else if (internalFreqSelect == clk_switch_pkg::FREQ_LOWEST) begin
      blockLevel = lowestUsesRc ? osc.slowRc
                   : state_r.postDiv[clk_switch_pkg::POST_WIDTH-1];
    end else begin
      blockLevel = postLevel;
    end
  end

  always_comb begin
    lines.primary       = osc.primary;
    lines.secondary     = osc.secondary;
    lines.internalBlock = blockLevel;
    rises               = lines & ~state_r.prevLines;
    falls               = ~lines & state_r.prevLines;
    oldLevel            = lineOf(lines, state_r.curSel);
    oldFall             = lineOf(falls, state_r.curSel);
    newRise             = lineOf(rises, state_r.tgtSel);
    newFall             = lineOf(falls, state_r.tgtSel);
  end

  // Secondary cannot be taken while its oscillator is off
  always_comb begin
    reqSel   = normSel(clockSourceSelect);
    reqValid = (reqSel != state_r.curSel) &&
               !(reqSel == clk_switch_pkg::SEL_SECONDARY &&
                 !secondaryOscEnable);
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_nxt           = state_r;
    state_nxt.prevLines = lines;
    state_nxt.prevFast  = osc.fastInternal;
    state_nxt.wdtClk    = osc.slowRc;
    if (osc.fastInternal && !state_r.prevFast) begin
      state_nxt.postDiv = state_r.postDiv + 1'b1;
    end

    case (state_r.swState)
      clk_switch_pkg::SW_RUN: begin
        state_nxt.devClk = oldLevel;
        if (reqValid) begin
          state_nxt.tgtSel  = reqSel;
          state_nxt.edgeCnt = 2'h0;
          state_nxt.swState = clk_switch_pkg::SW_DRAIN;
        end
      end
      // Output stops low after the old source's falling edge
      clk_switch_pkg::SW_DRAIN: begin
        if (state_r.edgeCnt == 2'h0) begin
          state_nxt.devClk = oldLevel & state_r.devClk;
        end else begin
          state_nxt.devClk = 1'b0;
        end
        if (oldFall) begin
          state_nxt.edgeCnt = state_r.edgeCnt + 1'b1;
          if (state_r.edgeCnt + 1'b1 == clk_switch_pkg::OLD_CYCLES) begin
            state_nxt.edgeCnt = 2'h0;
            state_nxt.curSel  = state_r.tgtSel;
            state_nxt.swState = clk_switch_pkg::SW_WAIT;
          end
        end
      end
      clk_switch_pkg::SW_WAIT: begin
        state_nxt.devClk = 1'b0;
        if (newRise) begin
          state_nxt.edgeCnt = state_r.edgeCnt + 1'b1;
          if (state_r.edgeCnt + 1'b1 == clk_switch_pkg::NEW_CYCLES) begin
            state_nxt.swState = clk_switch_pkg::SW_RESUME;
          end
        end
      end
      // Resume on a falling edge so the first high phase is whole
      clk_switch_pkg::SW_RESUME: begin
        state_nxt.devClk = 1'b0;
        if (newFall) begin
          state_nxt.edgeCnt = 2'h0;
          state_nxt.swState = clk_switch_pkg::SW_RUN;
        end
      end
      default: begin
        state_nxt.swState = clk_switch_pkg::SW_RUN;
      end
    endcase

    // Flags only while running; exclusive by the source compare
    state_nxt.status = '0;
    if (state_r.swState == clk_switch_pkg::SW_RUN) begin
      case (state_r.curSel)
        clk_switch_pkg::SEL_PRIMARY: begin
          state_nxt.status.primaryClockRunning = primaryStartupDone;
        end
        clk_switch_pkg::SEL_SECONDARY: begin
          state_nxt.status.secondaryClockRunning = 1'b1;
        end
        default: begin
          // Slow RC, or the block not ready, shows all flags clear
          state_nxt.status.internalClockStable = internalOscReady &&
            !(internalFreqSelect == clk_switch_pkg::FREQ_LOWEST &&
              lowestUsesRc);
        end
      endcase
    end

    // Wake wins over a sleep in the same cycle, as it ends the mode
    if (wakeEvent) begin
      state_nxt.sleepOn = 1'b0;
      state_nxt.idleOn  = 1'b0;
    end else if (sleepExecute) begin
      state_nxt.sleepOn = !idleOnSleepEnable;
      state_nxt.idleOn  = idleOnSleepEnable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= STATE_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign deviceClk             = state_r.devClk;
  assign watchdogClk           = state_r.wdtClk;
  assign primaryClockRunning   = state_r.status.primaryClockRunning;
  assign internalClockStable   = state_r.status.internalClockStable;
  assign secondaryClockRunning = state_r.status.secondaryClockRunning;
  assign sleepMode             = state_r.sleepOn;
  assign idleMode              = state_r.idleOn;
  assign switchBusy = (state_r.swState != clk_switch_pkg::SW_RUN);

endmodule : clock_source_switch

// ### src/clk_switch_pkg.sv
// Constants and types shared by the device clock source switch
package clk_switch_pkg;

  // Source selection encoding; 2'b11 also means the internal block
  localparam logic [1:0] SEL_PRIMARY   = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [1:0] SEL_INTERNAL  = 2'h2;
  localparam logic [1:0] SEL_RESET     = SEL_PRIMARY;

  // Internal frequency field codes
  localparam logic [2:0] FREQ_LOWEST = 3'h0;
  localparam logic [2:0] FREQ_FULL   = 3'h7;
  localparam logic [2:0] FREQ_RESET  = 3'h0;

  // Fast oscillator and postscaler figures
  localparam int FAST_OSC_KHZ   = 8000;
  localparam int LOWEST_DIVIDER = 256;
  localparam int POST_WIDTH     = $clog2(LOWEST_DIVIDER);
  localparam logic [POST_WIDTH-1:0] POST_RESET = 8'h00;
  // Counter bit that gives fast/2 is bit 0; code 6 maps there
  localparam logic [2:0] FREQ_TOP_POST = 3'h6;

  // Switch pause lengths, in cycles of the old and the new source
  localparam logic [1:0] OLD_CYCLES = 2'h2;
  localparam logic [1:0] NEW_CYCLES = 2'h3;

  // Synchronised oscillator lines, one bit each
  localparam int NUM_OSC = 4;
  typedef struct packed {
    logic slowRc;
    logic fastInternal;
    logic secondary;
    logic primary;
  } osc_lines_t;

  // Candidate device clock lines
  typedef struct packed {
    logic internalBlock;
    logic secondary;
    logic primary;
  } clk_lines_t;

  typedef struct packed {
    logic primaryClockRunning;
    logic internalClockStable;
    logic secondaryClockRunning;
  } status_t;

  // Gray coded along run, drain, wait, resume
  typedef enum logic [1:0] {
    SW_RUN    = 2'b00,
    SW_DRAIN  = 2'b01,
    SW_WAIT   = 2'b11,
    SW_RESUME = 2'b10
  } switch_state_t;

endpackage : clk_switch_pkg

// ### src/osc_sync.sv
// Two-flop synchronisers for the oscillator pins
`timescale 1ns/1ps
module osc_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stageOne_r;
  logic [WIDTH-1:0] stageTwo_r;

  // The first stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          stageOne_r[i] <= 1'b0;
          stageTwo_r[i] <= 1'b0;
        end else begin
          stageOne_r[i] <= asyncIn[i];
          stageTwo_r[i] <= stageOne_r[i];
        end
      end
    end
  endgenerate

  assign syncOut = stageTwo_r;

endmodule : osc_sync

// ### verif/clock_source_switch_props.sv
// Port assertions for the clock source switch
`timescale 1ns/1ps
module clock_source_switch_props (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [1:0] clockSourceSelect,
  input wire logic [2:0] internalFreqSelect,
  input wire logic       lowFreqSourceChoice,
  input wire logic       secondaryOscEnable,
  input wire logic       primaryStartupDone,
  input wire logic       internalOscReady,
  input wire logic       idleOnSleepEnable,
  input wire logic       sleepExecute,
  input wire logic       wakeEvent,
  input wire logic       primaryClockRunning,
  input wire logic       internalClockStable,
  input wire logic       secondaryClockRunning,
  input wire logic       sleepMode,
  input wire logic       idleMode,
  input wire logic       switchBusy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [2:0] flags;
  assign flags = {primaryClockRunning, internalClockStable,
                  secondaryClockRunning};
  // A fast/256 source switch lasts thousands of cycles, too long for a
  // delay range, so the busy span is counted instead
  localparam logic [15:0] BUSY_LIMIT = 16'h4000;
  logic [15:0] busyCnt_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busyCnt_r <= 16'h0;
    end else if (!switchBusy) begin
      busyCnt_r <= 16'h0;
    end else begin
      busyCnt_r <= busyCnt_r + 16'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  one_flag_a: assert property ($onehot0(flags))
    else $error("Several source flags set");
  busy_quiet_a: assert property (
    switchBusy && $past(switchBusy) |-> flags == 3'h0)
    else $error("Source flag set during switch");
  sleep_entry_a: assert property (
    sleepExecute && !wakeEvent |=> sleepMode == !$past(idleOnSleepEnable)
      && idleMode == $past(idleOnSleepEnable))
    else $error("Wrong mode after sleep");
  wake_clear_a: assert property (
    wakeEvent |=> !sleepMode && !idleMode)
    else $error("Mode kept after wake");
  refuse_sec_a: assert property (
    $rose(switchBusy) |-> !(!$past(secondaryOscEnable) &&
      $past(clockSourceSelect) == clk_switch_pkg::SEL_SECONDARY))
    else $error("Disabled secondary taken");
  switch_end_a: assert property (busyCnt_r < BUSY_LIMIT)
    else $error("Switch never completed");
  switch_min_a: assert property (
    $rose(switchBusy) |-> switchBusy[*4])
    else $error("Switch pause too short");
  primary_flag_a: assert property (
    primaryClockRunning |-> $past(primaryStartupDone))
    else $error("Primary flag before start-up");
  internal_flag_a: assert property (
    internalClockStable |-> $past(internalOscReady) &&
      !($past(internalFreqSelect) == 3'h0 && !$past(lowFreqSourceChoice)))
    else $error("Internal flag wrongly set");
  switch_c: cover property ($rose(switchBusy));
  idle_c: cover property ($rose(idleMode));
  stable_c: cover property ($rose(internalClockStable));
endmodule : clock_source_switch_props

bind clock_source_switch clock_source_switch_props props_i (
  .core_clk, .rstn, .clockSourceSelect, .internalFreqSelect,
  .lowFreqSourceChoice, .secondaryOscEnable, .primaryStartupDone,
  .internalOscReady, .idleOnSleepEnable, .sleepExecute, .wakeEvent,
  .primaryClockRunning, .internalClockStable, .secondaryClockRunning,
  .sleepMode, .idleMode, .switchBusy);

// ### verif/test_system_clock_source_switch.sv
// Self-checking bench for the clock source switch
`timescale 1ns/1ps
module test_system_clock_source_switch;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  osc = 4'h0;
  logic [1:0]  sel = 2'h0;
  logic [2:0]  freq = 3'h0;
  logic        lfc = 1'b0, en = 1'b1, stup = 1'b1, rdy = 1'b1;
  logic        idle = 1'b0, slp = 1'b0, wake = 1'b0;
  logic        dclk, wclk, pRun, iStab, sRun, sMode, iMode, busy;
  logic [1:0]  applied = 2'h0;
  logic [31:0] rng = 32'h0000255a;
  logic [2:0]  corner [4] = '{3'h2, 3'h3, 3'h7, 3'h1};
  int          fails = 0, nCompared = 0, cyc = 0, i, hi, lo, h;

  clock_source_switch clock_source_switch_i (
    .core_clk(core_clk), .rstn(rstn), .primaryOscIn(osc[0]),
    .secondaryOscIn(osc[1]), .fastInternalOscIn(osc[2]),
    .slowInternalRcIn(osc[3]), .clockSourceSelect(sel),
    .internalFreqSelect(freq), .lowFreqSourceChoice(lfc),
    .secondaryOscEnable(en), .primaryStartupDone(stup),
    .internalOscReady(rdy), .idleOnSleepEnable(idle),
    .sleepExecute(slp), .wakeEvent(wake), .deviceClk(dclk),
    .watchdogClk(wclk), .primaryClockRunning(pRun),
    .internalClockStable(iStab), .secondaryClockRunning(sRun),
    .sleepMode(sMode), .idleMode(iMode), .switchBusy(busy));

  always #4 core_clk = ~core_clk;
  // Sources kept slow against core_clk since pins are sampled by it
  always @(negedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc % 6 == 0) osc[0] <= ~osc[0];
    if (cyc % 20 == 0) osc[1] <= ~osc[1];
    if (cyc % 4 == 0) osc[2] <= ~osc[2];
    if (cyc % 16 == 0) osc[3] <= ~osc[3];
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : nextRand

  function automatic logic [2:0] expFlags();
    return {applied == 2'h0 && stup,
            applied == 2'h2 && rdy && !(freq == 3'h0 && !lfc),
            applied == 2'h1};
  endfunction : expFlags

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("compared=%0d mismatches=%0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic apply(input logic [1:0] s, input logic e);
    logic [1:0] n;
    logic       take;
    n = s[1] ? 2'h2 : s;
    take = (n != applied) && !(s == 2'h1 && !e);
    @(negedge core_clk);
    sel = s;
    en = e;
    repeat (2) @(negedge core_clk);
    chk(busy, take);
    while (busy) @(negedge core_clk);
    if (take) applied = n;
    repeat (3) @(negedge core_clk);
    chk({pRun, iStab, sRun}, expFlags());
  endtask : apply

  // Two lead-in cycles so a phase cut short by a code change is skipped
  task automatic phases(input logic w, output int hi, output int lo);
    hi = 0;
    lo = 0;
    repeat (2) begin
      while (w ? wclk : dclk) @(negedge core_clk);
      while (!(w ? wclk : dclk)) @(negedge core_clk);
    end
    while (w ? wclk : dclk) begin
      hi++;
      @(negedge core_clk);
    end
    while (!(w ? wclk : dclk)) begin
      lo++;
      @(negedge core_clk);
    end
  endtask : phases

  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    end_sim();
  end

  initial begin
    repeat (10) @(negedge core_clk);
    chk({dclk, pRun, iStab, sRun, sMode, iMode, busy}, 7'h00);
    rstn = 1'b1;
    for (i = 0; i < 16; i++) begin
      rng = nextRand(rng);
      if (i < 4) begin
        apply(corner[i][2:1], corner[i][0]);
      end else begin
        rdy = rng[3] | rng[4];
        stup = rng[9] | rng[10];
        freq = rng[7:5];
        // Fast/256 is left to the directed part to keep switches short
        lfc = rng[8] && (rng[7:5] != 3'h0);
        apply(rng[1:0], rng[2] | (applied == 2'h1));
      end
    end
    apply(2'h2, 1'b1);
    rstn = 1'b0;
    @(negedge core_clk);
    chk({pRun, iStab, sRun, busy}, 4'h0);
    rstn = 1'b1;
    applied = 2'h0;
    repeat (3) @(negedge core_clk);
    chk(busy, 1'b1);
    while (busy) @(negedge core_clk);
    applied = 2'h2;
    rdy = 1'b1;
    for (i = 0; i < 9; i++) begin
      freq = i[2:0];
      lfc = (i < 8);
      h = (freq == 3'h7) ? 4 : (freq == 3'h0) ? (lfc ? 1024 : 16) :
          4 << (7 - freq);
      phases(1'b0, hi, lo);
      chk(hi, h);
      chk(lo, h);
      chk({pRun, iStab, sRun}, expFlags());
    end
    lfc = 1'b1;
    phases(1'b1, hi, lo);
    chk(hi, 16);
    chk(lo, 16);
    for (i = 0; i < 8; i++) begin
      rng = nextRand(rng);
      idle = rng[0];
      slp = 1'b1;
      wake = rng[1] & rng[2];
      @(negedge core_clk);
      chk({sMode, iMode}, wake ? 2'h0 : {!idle, idle});
      slp = 1'b0;
      wake = 1'b1;
      @(negedge core_clk);
      chk({sMode, iMode}, 2'h0);
      wake = 1'b0;
      @(negedge core_clk);
    end
    end_sim();
  end
endmodule : test_system_clock_source_switch
